// [hw/ted_core.sv]
// Filter chain, event detectors, register port and interrupt of the detector
//
// Implementation choices: the strobed register port and the address map.
module ted_core #(
	parameter int unsigned SPACING_BASE = 1
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic sample_valid,
	input wire logic [ted_pkg::OBJ_W-1:0] raw_object_sample,
	input wire logic [ted_pkg::AMB_W-1:0] raw_ambient_sample,
	input wire logic [ted_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);

	localparam int OW = ted_pkg::OBJ_W;
	localparam int AW = ted_pkg::ACC_W;
	localparam int FR = AW - OW;

	// ----------------------------------------
	// Whole state
	// ----------------------------------------
	typedef struct packed {
		ted_pkg::ted_cfg_t cfg;
		logic [AW-1:0] fast_acc;
		logic [AW-1:0] slow_acc;
		logic [AW-1:0] amb_acc;
		logic [OW-1:0] object_slow_snapshot;
		logic [OW-1:0] motion_ref;
		logic [3:0] slot_cnt;
		logic pres_lvl;
		logic mot_lvl;
		logic shock_lvl;
		logic lim_lvl;
		logic [ted_pkg::NSRC-1:0] status;
		logic [31:0] rdata;
		logic started;
	} ted_state_t;

	ted_state_t s_q;
	ted_state_t s_d;

	// Magnitude of signed difference
	function automatic logic [OW:0] tc_mag(input logic signed [OW+1:0] v);
		logic signed [OW+1:0] a;
		a = (v < 0) ? -v : v;
		return a[OW:0];
	endfunction : tc_mag

	// Hysteresis comparator: set above thr, clear below thr minus max(thr/8, floor)
	function automatic logic tc_hyst(input logic lvl, input logic [OW:0] m,
		input logic [ted_pkg::THR_W-1:0] thr);
		logic [ted_pkg::THR_W-1:0] h;
		logic [OW:0] lo;
		h = thr >> ted_pkg::HYST_SHIFT;
		if (h < ted_pkg::HYST_MIN) begin
			h = ted_pkg::HYST_MIN;
		end
		lo = (thr > h) ? (OW+1)'(thr - h) : '0;
		if (m > (OW+1)'(thr)) begin
			return 1'b1;
		end
		if (m < lo) begin
			return 1'b0;
		end
		return lvl;
	endfunction : tc_hyst

	// ----------------------------------------
	// Datapath view of the filters
	// ----------------------------------------
	logic [OW-1:0] object_fast_filtered;
	logic [OW-1:0] object_slow_filtered;
	logic [OW-1:0] ambient_filtered;
	logic signed [OW+1:0] presence_value;
	logic signed [OW+1:0] motion_value;
	logic signed [OW+1:0] ambient_shock_value;
	logic [OW-1:0] limit_ext;
	logic [3:0] slot_max;

	assign object_fast_filtered = s_q.fast_acc[AW-1:FR];
	assign object_slow_filtered = s_q.slow_acc[AW-1:FR];
	assign ambient_filtered = s_q.amb_acc[AW-1:FR];
	assign limit_ext = {s_q.cfg.object_limit, 1'b0};
	// Intervals 30/60/120/240 ms as 1,2,4,8 sample slots
	assign slot_max = 4'(({3'h0, 1'b1} << s_q.cfg.cycle_sel) * SPACING_BASE) - 4'h1;

	// Presence path pair select
	always_comb begin
		unique case (s_q.cfg.presence_path_choice)
			ted_pkg::TED_RAW_SLOW:
				presence_value = $signed({2'b00, raw_object_sample})
					- $signed({2'b00, object_slow_filtered});
			ted_pkg::TED_FAST_SLOW:
				presence_value = $signed({2'b00, object_fast_filtered})
					- $signed({2'b00, object_slow_filtered});
			ted_pkg::TED_RAW_SNAP:
				presence_value = $signed({2'b00, raw_object_sample})
					- $signed({2'b00, s_q.object_slow_snapshot});
			ted_pkg::TED_FAST_SNAP:
				presence_value = $signed({2'b00, object_fast_filtered})
					- $signed({2'b00, s_q.object_slow_snapshot});
		endcase
	end

	// Motion difference from the fast filter, shock difference from the raw ambient sample
	assign motion_value = $signed({2'b00, object_fast_filtered})
		- $signed({2'b00, s_q.motion_ref});
	assign ambient_shock_value = $signed({4'h0, raw_ambient_sample})
		- $signed({2'b00, ambient_filtered});

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [AW-1:0] xo;
		logic [AW-1:0] xa;
		logic nl;
		logic pres_n;
		logic mot_n;
		logic shock_n;
		logic lim_n;
		logic [ted_pkg::NSRC-1:0] ev;
		xo = '0;
		xa = '0;
		nl = 1'b0;
		pres_n = 1'b0;
		mot_n = 1'b0;
		shock_n = 1'b0;
		lim_n = 1'b0;
		ev = '0;
		s_d = s_q;
		s_d.started = 1'b1;
		// Register writes take effect at once, no restart
		if (reg_wr) begin
			unique case (reg_addr)
				ted_pkg::REG_FAST_COEFF: s_d.cfg.fast_filter_coeff = reg_wdata[ted_pkg::COEF_W-1:0];
				ted_pkg::REG_SLOW_COEFF: s_d.cfg.slow_filter_coeff = reg_wdata[ted_pkg::COEF_W-1:0];
				ted_pkg::REG_AMB_COEFF: s_d.cfg.ambient_filter_coeff = reg_wdata[ted_pkg::COEF_W-1:0];
				ted_pkg::REG_PRES_THR: s_d.cfg.pres_thr = reg_wdata[ted_pkg::THR_W-1:0];
				ted_pkg::REG_MOT_THR: s_d.cfg.mot_thr = reg_wdata[ted_pkg::THR_W-1:0];
				ted_pkg::REG_SHOCK_THR: s_d.cfg.shock_thr = reg_wdata[ted_pkg::THR_W-1:0];
				ted_pkg::REG_MASK: s_d.cfg.mask = reg_wdata[ted_pkg::NSRC-1:0];
				ted_pkg::REG_MULTI: begin
					s_d.cfg.limit_direction = reg_wdata[ted_pkg::MULTI_DIR_BIT];
					s_d.cfg.presence_path_choice =
						ted_pkg::ted_path_t'(reg_wdata[ted_pkg::MULTI_SRC_LSB +: 2]);
					s_d.cfg.cycle_sel = reg_wdata[ted_pkg::MULTI_CYC_LSB +: 2];
				end
				ted_pkg::REG_LIMIT: s_d.cfg.object_limit = reg_wdata[ted_pkg::LIM_W-1:0];
				default: ;
			endcase
		end
		// Read data, valid only in the cycle after the strobe
		s_d.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				ted_pkg::REG_FAST_COEFF: s_d.rdata = 32'(s_q.cfg.fast_filter_coeff);
				ted_pkg::REG_SLOW_COEFF: s_d.rdata = 32'(s_q.cfg.slow_filter_coeff);
				ted_pkg::REG_AMB_COEFF: s_d.rdata = 32'(s_q.cfg.ambient_filter_coeff);
				ted_pkg::REG_PRES_THR: s_d.rdata = 32'(s_q.cfg.pres_thr);
				ted_pkg::REG_MOT_THR: s_d.rdata = 32'(s_q.cfg.mot_thr);
				ted_pkg::REG_SHOCK_THR: s_d.rdata = 32'(s_q.cfg.shock_thr);
				ted_pkg::REG_MASK: s_d.rdata = 32'(s_q.cfg.mask);
				ted_pkg::REG_MULTI: s_d.rdata = 32'({s_q.cfg.limit_direction,
					s_q.cfg.presence_path_choice, s_q.cfg.cycle_sel});
				ted_pkg::REG_LIMIT: s_d.rdata = 32'(s_q.cfg.object_limit);
				ted_pkg::REG_STATUS: s_d.rdata = 32'(s_q.status);
				ted_pkg::REG_LEVELS: s_d.rdata = 32'({s_q.lim_lvl, s_q.pres_lvl,
					s_q.mot_lvl, s_q.shock_lvl, 1'b0});
				default: s_d.rdata = '0;
			endcase
			if (reg_addr == ted_pkg::REG_STATUS) begin
				s_d.status = '0;
			end
		end
		// Sample processing, once per sample enable
		if (sample_valid) begin
			// acc += (x - acc) >> s : first-order recursive low pass
			xo = {raw_object_sample, {FR{1'b0}}};
			xa = {{(OW-ted_pkg::AMB_W){1'b0}}, raw_ambient_sample, {FR{1'b0}}};
			s_d.fast_acc = s_q.fast_acc + AW'($signed(xo - s_q.fast_acc)
				>>> (ted_pkg::COEF_W'(15) - s_q.cfg.fast_filter_coeff));
			s_d.slow_acc = s_q.slow_acc + AW'($signed(xo - s_q.slow_acc)
				>>> (ted_pkg::COEF_W'(15) - s_q.cfg.slow_filter_coeff));
			s_d.amb_acc = s_q.amb_acc + AW'($signed(xa - s_q.amb_acc)
				>>> (ted_pkg::COEF_W'(15) - s_q.cfg.ambient_filter_coeff));
			pres_n = tc_hyst(s_q.pres_lvl, tc_mag(presence_value), s_q.cfg.pres_thr);
			shock_n = tc_hyst(s_q.shock_lvl, tc_mag(ambient_shock_value),
				s_q.cfg.shock_thr);
			mot_n = s_q.mot_lvl;
			if (s_q.slot_cnt >= slot_max) begin
				s_d.slot_cnt = '0;
				s_d.motion_ref = object_fast_filtered;
				mot_n = tc_hyst(s_q.mot_lvl, tc_mag(motion_value), s_q.cfg.mot_thr);
			end else begin
				s_d.slot_cnt = s_q.slot_cnt + 4'h1;
			end
			if (mot_n && !s_q.mot_lvl) begin
				s_d.object_slow_snapshot = object_slow_filtered;
			end
			// Limit compare with fixed band; dir selects above/below
			if (s_q.cfg.limit_direction) begin
				nl = s_q.lim_lvl ? (raw_object_sample + ted_pkg::LIMIT_HYST > limit_ext)
					: (raw_object_sample > limit_ext);
			end else begin
				nl = s_q.lim_lvl ? (raw_object_sample < limit_ext + ted_pkg::LIMIT_HYST)
					: (raw_object_sample < limit_ext);
			end
			lim_n = nl;
			// Flags set on inactive-to-active edges only
			ev[ted_pkg::ST_LIMIT] = lim_n && !s_q.lim_lvl;
			ev[ted_pkg::ST_PRES] = pres_n && !s_q.pres_lvl;
			ev[ted_pkg::ST_MOT] = mot_n && !s_q.mot_lvl;
			ev[ted_pkg::ST_SHOCK] = shock_n && !s_q.shock_lvl;
			s_d.pres_lvl = pres_n;
			s_d.mot_lvl = mot_n;
			s_d.shock_lvl = shock_n;
			s_d.lim_lvl = lim_n;
			// Set wins over a read clear in the same cycle
			s_d.status = s_d.status | ev;
		end
	end

	// ----------------------------------------
	// State register; reset presets limit flag and mask
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.status <= ted_pkg::RST_STATUS[ted_pkg::NSRC-1:0];
			s_q.cfg.mask <= ted_pkg::RST_MASK[ted_pkg::NSRC-1:0];
			s_q.cfg.fast_filter_coeff <= ted_pkg::RST_COEFF;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// Interrupt is masked OR of status flags
	assign irq = |(s_q.status & s_q.cfg.mask);
	assign reg_rdata = s_q.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_b)
		irq == |(s_q.status & s_q.cfg.mask))
		else $error("irq not masked OR of status");
	AST_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && reg_rd && reg_addr == ted_pkg::REG_STATUS && !sample_valid
		|=> s_q.status == '0)
		else $error("status not cleared by read");
	AST_SNAPSHOT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(s_q.mot_lvl) |-> s_q.object_slow_snapshot == $past(object_slow_filtered))
		else $error("snapshot not captured on motion");
	AST_NO_SAMPLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(sample_valid) |-> $stable(s_q.fast_acc) && $stable(s_q.pres_lvl))
		else $error("filter moved without sample");
	AST_LIMIT_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(s_q.status[ted_pkg::ST_LIMIT]) && s_q.started |-> $rose(s_q.lim_lvl))
		else $error("limit flag without crossing");
	AST_PRES_SET: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && sample_valid && tc_mag(presence_value) > 18'(s_q.cfg.pres_thr)
		|=> s_q.pres_lvl)
		else $error("presence level not set");
	AST_PRES_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && sample_valid && s_q.pres_lvl
		&& tc_mag(presence_value) + 18'(ted_pkg::HYST_MIN) >= 18'(s_q.cfg.pres_thr)
		|=> s_q.pres_lvl)
		else $error("presence cleared inside band");
	AST_RDATA_ONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");

endmodule : ted_core

// [hw/ted_pkg.sv]
// Package of constants and types for the thermal event detector
package ted_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int OBJ_W = 17;
	localparam int AMB_W = 15;
	localparam int ACC_W = 24;
	localparam int THR_W = 8;
	localparam int LIM_W = 16;
	localparam int COEF_W = 4;
	localparam int ADDR_W = 5;

	// ----------------------------------------
	// Register indexes (word addresses on the plain port)
	// ----------------------------------------
	localparam logic [4:0] REG_FAST_COEFF = 5'h00;
	localparam logic [4:0] REG_SLOW_COEFF = 5'h01;
	localparam logic [4:0] REG_AMB_COEFF = 5'h02;
	localparam logic [4:0] REG_PRES_THR = 5'h03;
	localparam logic [4:0] REG_MOT_THR = 5'h04;
	localparam logic [4:0] REG_SHOCK_THR = 5'h05;
	localparam logic [4:0] REG_MASK = 5'h06;
	localparam logic [4:0] REG_MULTI = 5'h07;
	localparam logic [4:0] REG_LIMIT = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h09;
	localparam logic [4:0] REG_LEVELS = 5'h0A;

	// ----------------------------------------
	// Field positions of the multiple-setting register
	// ----------------------------------------
	localparam int MULTI_DIR_BIT = 4;
	localparam int MULTI_SRC_LSB = 2;
	localparam int MULTI_CYC_LSB = 0;

	// Status / mask bit order
	localparam int ST_LIMIT = 4;
	localparam int ST_PRES = 3;
	localparam int ST_MOT = 2;
	localparam int ST_SHOCK = 1;
	localparam int NSRC = 5;

	// ----------------------------------------
	// Hysteresis and timing
	// ----------------------------------------
	localparam int HYST_SHIFT = 3;
	localparam logic [THR_W-1:0] HYST_MIN = 8'h05;
	localparam logic [OBJ_W-1:0] LIMIT_HYST = 17'h00040;
	localparam int LIMIT_SCALE = 1;
	localparam int SAMPLE_MS = 30;
	localparam logic [7:0] RST_MASK = 8'h10;
	localparam logic [7:0] RST_STATUS = 8'h10;
	localparam logic [COEF_W-1:0] RST_COEFF = 4'h0;

	// Presence path pairs
	typedef enum logic [1:0] {
		TED_RAW_SLOW = 2'b00,
		TED_FAST_SLOW = 2'b01,
		TED_RAW_SNAP = 2'b10,
		TED_FAST_SNAP = 2'b11
	} ted_path_t;

	// Software settings
	typedef struct packed {
		logic [COEF_W-1:0] fast_filter_coeff;
		logic [COEF_W-1:0] slow_filter_coeff;
		logic [COEF_W-1:0] ambient_filter_coeff;
		logic [THR_W-1:0] pres_thr;
		logic [THR_W-1:0] mot_thr;
		logic [THR_W-1:0] shock_thr;
		logic [NSRC-1:0] mask;
		logic limit_direction;
		ted_path_t presence_path_choice;
		logic [1:0] cycle_sel;
		logic [LIM_W-1:0] object_limit;
	} ted_cfg_t;

endpackage : ted_pkg

// [test/ted_host_model.sv]
// Host controller model that drives the register port of the detector
module ted_host_model (
	input wire logic clk_sys,
	output logic [ted_pkg::ADDR_W-1:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Idle bus
	// ----------------------------------------
	// Quiet port at time zero
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// One-cycle write; released lines show inverted data so stale values never match
	task automatic wr(input logic [ted_pkg::ADDR_W-1:0] addr, input logic [31:0] data);
		@(posedge clk_sys);
		reg_addr <= addr;
		reg_wdata <= data;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask : wr

	// One-cycle read; the data is picked up by the bench watcher a cycle later
	task automatic rd(input logic [ted_pkg::ADDR_W-1:0] addr);
		@(posedge clk_sys);
		reg_addr <= addr;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~addr;
	endtask : rd
endmodule : ted_host_model

// [test/testbench.sv]
// Self-checking testbench of the thermal event detector core
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] msk;
	} ted_note_t;

	logic clk_sys;
	logic rst_b;
	logic clk_en;
	logic sample_valid;
	logic [ted_pkg::OBJ_W-1:0] raw_object_sample;
	logic [ted_pkg::AMB_W-1:0] raw_ambient_sample;
	logic [ted_pkg::ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic irq;
	logic rd_seen_q;
	int bad_count;
	int checks;
	ted_note_t notes[$];
	logic [4:0] ra[4] = '{5'h03, 5'h04, 5'h05, 5'h08};
	logic [31:0] rm[4] = '{32'h000000FF, 32'h000000FF, 32'h000000FF, 32'h0000FFFF};
	logic [31:0] v;
	logic [16:0] obj;

	ted_host_model ted_host_model_i (
		.clk_sys(clk_sys),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd)
	);

	ted_core #(.SPACING_BASE(1)) ted_core_i (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.sample_valid(sample_valid),
		.raw_object_sample(raw_object_sample),
		.raw_ambient_sample(raw_ambient_sample),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq(irq)
	);

	// ----------------------------------------
	// Clock, watcher and watchdog
	// ----------------------------------------
	// 40 MHz sample clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Read data stands only in the cycle after the strobe, so look at mid-cycle
	always @(posedge clk_sys) rd_seen_q <= reg_rd;
	always @(negedge clk_sys) begin
		ted_note_t n;
		if (rd_seen_q === 1'b1) begin
			n = notes.pop_front();
			checks++;
			if ((reg_rdata & n.msk) !== (n.exp & n.msk)) begin
				bad_count++;
				$display("[ERR] reg_rdata expected %h seen %h", n.exp & n.msk, reg_rdata & n.msk);
			end
		end
	end

	// Whole run is well under a thousand cycles; generous margin for a hang
	initial begin
		#(25 * 20000);
		bad_count++;
		$display("[ERR] watchdog expected done seen hang");
		summarize();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Note the expected word, then let the host read it
	task automatic rd(input logic [4:0] addr, input logic [31:0] exp, input logic [31:0] msk);
		notes.push_back('{exp: exp, msk: msk});
		ted_host_model_i.rd(addr);
	endtask : rd

	task automatic wr(input logic [4:0] addr, input logic [31:0] data);
		ted_host_model_i.wr(addr, data);
	endtask : wr

	// One ADC sample pulse; lines go stale-inverted afterwards
	task automatic put(input logic [16:0] o, input logic [14:0] a);
		@(posedge clk_sys);
		raw_object_sample <= o;
		raw_ambient_sample <= a;
		sample_valid <= 1'b1;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		raw_object_sample <= ~o;
		raw_ambient_sample <= ~a;
	endtask : put

	// Irq is looked at once the edge's updates have landed
	task automatic chk_irq(input logic exp);
		#1;
		checks++;
		if (irq !== exp) begin
			bad_count++;
			$display("[ERR] irq expected %b seen %b", exp, irq);
		end
	endtask : chk_irq

	task automatic test_end(input string name);
		$display("test %s done, mismatches so far %0d", name, bad_count);
	endtask : test_end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_en = 1'b1;
		rst_b = 1'b0;
		sample_valid = 1'b0;
		raw_object_sample = 17'h00000;
		raw_ambient_sample = 15'h0000;
		rd_seen_q = 1'b0;
		bad_count = 0;
		checks = 0;
		void'($urandom(32'h57AA));
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		// Start-up event and reset values
		chk_irq(1'b1);
		rd(ted_pkg::REG_MASK, {24'h000000, ted_pkg::RST_MASK}, 32'h0000001F);
		rd(ted_pkg::REG_FAST_COEFF, {28'h0000000, ted_pkg::RST_COEFF}, 32'h0000000F);
		rd(ted_pkg::REG_STATUS, {24'h000000, ted_pkg::RST_STATUS}, 32'h0000001F);
		chk_irq(1'b0);
		test_end("reset");
		// Settings take effect at run time; unmapped index ignored
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			wr(ra[i], v);
			rd(ra[i], v, rm[i]);
		end
		wr(5'h1F, v);
		rd(5'h1F, 32'h00000000, 32'hFFFFFFFF);
		// Limit zero with falling direction keeps the limit detector quiet until its own test
		wr(ted_pkg::REG_LIMIT, 32'h00000000);
		test_end("registers");
		// Presence: slow path stays at zero, so every pair sees the raw value
		wr(ted_pkg::REG_FAST_COEFF, 32'h0000000F);
		wr(ted_pkg::REG_SLOW_COEFF, 32'h00000000);
		wr(ted_pkg::REG_PRES_THR, 32'h00000032);
		for (int p = 0; p < 4; p++) begin
			wr(ted_pkg::REG_MULTI, 32'(p) << ted_pkg::MULTI_SRC_LSB);
			// Fast path compares last sample's filter value, so each level goes in twice
			put(17'h00028, 15'h0000);
			put(17'h00028, 15'h0000);
			rd(ted_pkg::REG_LEVELS, 32'h00000000, 32'h00000008);
			put(17'h00033, 15'h0000);
			put(17'h00033, 15'h0000);
			rd(ted_pkg::REG_LEVELS, 32'h00000008, 32'h00000008);
		end
		// Raw path for the band checks, no filter lag
		wr(ted_pkg::REG_MULTI, 32'h00000000);
		put(17'h0002D, 15'h0000);
		rd(ted_pkg::REG_LEVELS, 32'h00000008, 32'h00000008);
		put(17'h0002B, 15'h0000);
		rd(ted_pkg::REG_LEVELS, 32'h00000000, 32'h00000008);
		wr(ted_pkg::REG_PRES_THR, 32'h00000010);
		put(17'h00011, 15'h0000);
		put(17'h0000B, 15'h0000);
		rd(ted_pkg::REG_LEVELS, 32'h00000008, 32'h00000008);
		put(17'h0000A, 15'h0000);
		rd(ted_pkg::REG_LEVELS, 32'h00000000, 32'h00000008);
		test_end("presence");
		// Motion: ramp of 2 per sample, spacing 1,2,4,8 gives 2,4,8,16 against 8
		wr(ted_pkg::REG_MOT_THR, 32'h00000008);
		obj = 17'h0000C;
		for (int c = 0; c < 4; c++) begin
			wr(ted_pkg::REG_MULTI, 32'(c));
			for (int k = 0; k < 16; k++) begin
				put(obj, 15'h0000);
				obj = obj + 17'h00002;
			end
			rd(ted_pkg::REG_LEVELS, (c == 3) ? 32'h00000004 : 32'h00000000, 32'h00000004);
		end
		test_end("motion");
		// Object limit at 2 x 0x1000, rising then falling direction
		wr(ted_pkg::REG_MASK, 32'h00000000);
		wr(ted_pkg::REG_MULTI, 32'h00000010);
		wr(ted_pkg::REG_LIMIT, 32'h00001000);
		put(17'h02000, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000000, 32'h00000010);
		put(17'h02001, 15'h0000);
		chk_irq(1'b0);
		wr(ted_pkg::REG_MASK, 32'h00000010);
		chk_irq(1'b1);
		rd(ted_pkg::REG_STATUS, 32'h00000010, 32'h00000010);
		chk_irq(1'b0);
		put(17'h02001, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000000, 32'h00000010);
		put(17'h01FC1, 15'h0000);
		put(17'h02001, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000000, 32'h00000010);
		put(17'h01FC0, 15'h0000);
		put(17'h02001, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000010, 32'h00000010);
		wr(ted_pkg::REG_MULTI, 32'h00000000);
		put(17'h02040, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000000, 32'h00000010);
		put(17'h01FFF, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000010, 32'h00000010);
		put(17'h0203F, 15'h0000);
		put(17'h01FFF, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000000, 32'h00000010);
		put(17'h02040, 15'h0000);
		put(17'h01FFF, 15'h0000);
		rd(ted_pkg::REG_STATUS, 32'h00000010, 32'h00000010);
		test_end("limit");
		// Ambient shock against threshold 10, floor hysteresis 5
		wr(ted_pkg::REG_AMB_COEFF, 32'h00000000);
		wr(ted_pkg::REG_SHOCK_THR, 32'h0000000A);
		put(17'h01FFF, 15'h000A);
		rd(ted_pkg::REG_LEVELS, 32'h00000000, 32'h00000002);
		put(17'h01FFF, 15'h000B);
		rd(ted_pkg::REG_LEVELS, 32'h00000002, 32'h00000002);
		put(17'h01FFF, 15'h0006);
		rd(ted_pkg::REG_LEVELS, 32'h00000002, 32'h00000002);
		put(17'h01FFF, 15'h0004);
		rd(ted_pkg::REG_LEVELS, 32'h00000000, 32'h00000002);
		test_end("shock");
		repeat (3) @(posedge clk_sys);
		summarize();
	end
endmodule : testbench
